// ---- hw/pbc_pkg.sv ----
// Shared constants, register map and carrier types of the basic control and status registers.
package pbc_pkg;

    // ==========================================================================
    // Register addresses on the serial management interface
    // ==========================================================================
    localparam logic [4:0] PBC_ADDR_CTRL   = 5'h00;
    localparam logic [4:0] PBC_ADDR_STATUS = 5'h01;
    localparam logic [4:0] PBC_ADDR_ID_HI  = 5'h02;
    localparam logic [4:0] PBC_ADDR_ID_LO  = 5'h03;
    localparam logic [4:0] PBC_ADDR_PAGE   = 5'h1f;

    // ==========================================================================
    // Field positions of port_mode_control
    // ==========================================================================
    localparam int PBC_CTRL_SRESET  = 15;
    localparam int PBC_CTRL_LOOP    = 14;
    localparam int PBC_CTRL_SPD_LSB = 13;
    localparam int PBC_CTRL_AN_EN   = 12;
    localparam int PBC_CTRL_PDOWN   = 11;
    localparam int PBC_CTRL_ISOLATE = 10;
    localparam int PBC_CTRL_AN_RST  = 9;
    localparam int PBC_CTRL_DUPLEX  = 8;
    localparam int PBC_CTRL_COLL    = 7;
    localparam int PBC_CTRL_SPD_MSB = 6;

    // ==========================================================================
    // Field positions of port_mode_status (live and latched bits)
    // ==========================================================================
    localparam int PBC_STAT_AN_DONE = 5;
    localparam int PBC_STAT_FAULT   = 4;
    localparam int PBC_STAT_LINK    = 2;
    localparam int PBC_STAT_JABBER  = 1;

    // ==========================================================================
    // Reset values and fixed readouts
    // ==========================================================================
    localparam logic [15:0] PBC_CTRL_RST   = 16'h1040;
    localparam logic [15:0] PBC_PAGE_RST   = 16'h0000;
    localparam logic [15:0] PBC_STAT_FIXED = 16'h79c9;
    localparam logic [15:0] PBC_MAIN_PAGE  = 16'h0000;

    // ==========================================================================
    // Management frame framing and timing counts
    // ==========================================================================
    localparam logic [1:0] PBC_OP_READ   = 2'b10;
    localparam logic [1:0] PBC_OP_WRITE  = 2'b01;
    localparam logic [3:0] PBC_HDR_LAST  = 4'hb;
    localparam logic [3:0] PBC_DATA_LAST = 4'hf;
    localparam int         PBC_SYNC_STAGES = 3;

    // Speed codes of the forced speed field.
    typedef enum logic [1:0] {
        PBC_SPD_10   = 2'b00,
        PBC_SPD_100  = 2'b01,
        PBC_SPD_1000 = 2'b10,
        PBC_SPD_RSVD = 2'b11
    } pbc_speed_t;

    // Frame receiver states.
    typedef enum logic [2:0] {
        PBC_IDLE,
        PBC_START,
        PBC_HDR,
        PBC_TA,
        PBC_DATA
    } pbc_fsm_t;

    // Control settings handed to the port datapath.
    typedef struct packed {
        logic       loopback;
        pbc_speed_t speed;
        logic       an_enable;
        logic       power_down;
        logic       isolate;
        logic       full_duplex;
        logic       coll_test;
    } pbc_ctrl_t;

    // Live conditions reported by the media side.
    typedef struct packed {
        logic link_up;
        logic jabber;
        logic far_fault;
        logic an_done;
    } pbc_media_t;

    // State of the synchroniser.
    typedef struct packed {
        logic [PBC_SYNC_STAGES-1:0] stage;
        logic                       q;
    } pbc_sync_state_t;

    // State of the register block.
    typedef struct packed {
        pbc_fsm_t    fsm;
        logic [3:0]  bcnt;
        logic [15:0] sr;
        logic [4:0]  regad;
        logic        rd;
        logic        wr;
        logic        mdc_prev;
        logic        mdio_out;
        logic        mdio_oe;
        logic [15:0] page;
        pbc_ctrl_t   ctrl;
        logic        an_restart;
        logic        sreset;
        logic        far_lat;
        logic        link_lat;
        logic        jab_lat;
    } pbc_state_t;

endpackage

// ---- hw/pbc_regs.sv ----
// Basic control, status and identity registers of one transceiver port behind its management pins.
`timescale 1ns/1ns
`default_nettype none

module pbc_regs
    import pbc_pkg::*;
#(
    parameter logic [21:0] MAKER_CODE = 22'h15a3c1,  // Arbitrary neutral value.
    parameter logic [5:0]  MODEL_NUM  = 6'h2d,       // Arbitrary neutral value.
    parameter logic [3:0]  REV_NUM    = 4'h3         // Arbitrary neutral value.
) (
    // Clock, reset and enable
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    // Management pins
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe_o,
    input  wire logic [4:0] phy_addr_i,
    // Media side status
    input  wire pbc_media_t media_i,
    // Port control
    output pbc_ctrl_t       ctrl_o,
    output logic            an_restart_o,
    output logic            soft_reset_o
);

    pbc_state_t  cur;
    pbc_state_t  next_cur;
    logic        mdc_s;
    logic        mdio_s;
    logic        mdc_rise;
    logic [15:0] ctrl_word;
    logic [15:0] stat_word;
    logic [15:0] rdata;
    logic [15:0] hdr;
    logic [15:0] shifted;
    logic        main_page;
    logic        stat_clr;
    logic        addr_hit;
    logic        ctrl_write;
    pbc_ctrl_t   ctrl_wr;

    // Control defaults are taken bit by bit from the reset word, so the two cannot drift.
    localparam pbc_ctrl_t CTRL_DEF = '{
        loopback:    PBC_CTRL_RST[PBC_CTRL_LOOP],
        speed:       pbc_speed_t'({PBC_CTRL_RST[PBC_CTRL_SPD_MSB],
                                   PBC_CTRL_RST[PBC_CTRL_SPD_LSB]}),
        an_enable:   PBC_CTRL_RST[PBC_CTRL_AN_EN],
        power_down:  PBC_CTRL_RST[PBC_CTRL_PDOWN],
        isolate:     PBC_CTRL_RST[PBC_CTRL_ISOLATE],
        full_duplex: PBC_CTRL_RST[PBC_CTRL_DUPLEX],
        coll_test:   PBC_CTRL_RST[PBC_CTRL_COLL]
    };

    // ==========================================================================
    // Pin synchronisers
    // ==========================================================================
    pbc_sync #(.RST_VAL(1'b0)) u_sync_mdc (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .ce_i       (ce_i),
        .din_i      (mdc_i),
        .q_o        (mdc_s)
    );

    // The management line idles high, so its filter starts high too.
    pbc_sync #(.RST_VAL(1'b1)) u_sync_mdio (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .ce_i       (ce_i),
        .din_i      (mdio_i),
        .q_o        (mdio_s)
    );

    // ==========================================================================
    // Register readouts
    // ==========================================================================
    // Control word as software reads it; self-clearing bits always read zero.
    always_comb begin
        ctrl_word                   = 16'h0000;
        ctrl_word[PBC_CTRL_LOOP]    = cur.ctrl.loopback;
        ctrl_word[PBC_CTRL_SPD_LSB] = cur.ctrl.speed[0];
        ctrl_word[PBC_CTRL_SPD_MSB] = cur.ctrl.speed[1];
        ctrl_word[PBC_CTRL_AN_EN]   = cur.ctrl.an_enable;
        ctrl_word[PBC_CTRL_PDOWN]   = cur.ctrl.power_down;
        ctrl_word[PBC_CTRL_ISOLATE] = cur.ctrl.isolate;
        ctrl_word[PBC_CTRL_DUPLEX]  = cur.ctrl.full_duplex;
        ctrl_word[PBC_CTRL_COLL]    = cur.ctrl.coll_test;
    end

    // Status word: fixed capabilities plus live and latched conditions.
    always_comb begin
        stat_word                   = PBC_STAT_FIXED;
        stat_word[PBC_STAT_AN_DONE] = media_i.an_done;
        stat_word[PBC_STAT_FAULT]   = cur.far_lat;
        stat_word[PBC_STAT_LINK]    = cur.link_lat;
        stat_word[PBC_STAT_JABBER]  = cur.jab_lat;
    end

    assign main_page = (cur.page == PBC_MAIN_PAGE);

    // Read multiplexer; main-page words read zero while another page is selected.
    always_comb begin
        rdata = 16'h0000;
        if (cur.regad == PBC_ADDR_PAGE) begin
            rdata = cur.page;
        end else if (main_page) begin
            unique case (cur.regad)
                PBC_ADDR_CTRL:   rdata = ctrl_word;
                PBC_ADDR_STATUS: rdata = stat_word;
                PBC_ADDR_ID_HI:  rdata = MAKER_CODE[21:6];
                PBC_ADDR_ID_LO:  rdata = {MAKER_CODE[5:0], MODEL_NUM, REV_NUM};
                default:         rdata = 16'h0000;
            endcase
        end
    end

    assign mdc_rise = mdc_s & ~cur.mdc_prev;
    assign hdr      = {cur.sr[14:0], mdio_s};
    assign shifted  = {cur.sr[14:0], mdio_s};
    assign stat_clr = ce_i && mdc_rise && (cur.fsm == PBC_TA) && (cur.bcnt == 4'h1)
                      && cur.rd && main_page && (cur.regad == PBC_ADDR_STATUS);
    assign addr_hit   = (hdr[9:5] == phy_addr_i);
    assign ctrl_write = cur.wr && main_page && (cur.regad == PBC_ADDR_CTRL);

    // Control fields carried by a written word; bits 15 and 9 are strobes and never stored.
    always_comb begin
        ctrl_wr.loopback    = shifted[PBC_CTRL_LOOP];
        ctrl_wr.speed       = pbc_speed_t'({shifted[PBC_CTRL_SPD_MSB],
                                            shifted[PBC_CTRL_SPD_LSB]});
        ctrl_wr.an_enable   = shifted[PBC_CTRL_AN_EN];
        ctrl_wr.power_down  = shifted[PBC_CTRL_PDOWN];
        ctrl_wr.isolate     = shifted[PBC_CTRL_ISOLATE];
        ctrl_wr.full_duplex = shifted[PBC_CTRL_DUPLEX];
        ctrl_wr.coll_test   = shifted[PBC_CTRL_COLL];
    end

    // ==========================================================================
    // Frame receiver, register writes and status latches
    // ==========================================================================
    // The clock of the controller may stop between frames; every step waits for a
    // rising edge, so nothing depends on the clock running idle.
    always_comb begin
        next_cur = cur;
        if (ce_i) begin
            next_cur.mdc_prev   = mdc_s;
            next_cur.an_restart = 1'b0;
            next_cur.sreset     = 1'b0;
            if (mdc_rise) begin
                unique case (cur.fsm)
                    // No preamble count is needed: a zero then a one starts a frame.
                    PBC_IDLE: begin
                        if (!mdio_s) begin
                            next_cur.fsm = PBC_START;
                        end
                    end
                    PBC_START: begin
                        if (mdio_s) begin
                            next_cur.fsm  = PBC_HDR;
                            next_cur.bcnt = 4'h0;
                        end
                    end
                    PBC_HDR: begin
                        next_cur.sr   = hdr;
                        next_cur.bcnt = cur.bcnt + 4'h1;
                        if (cur.bcnt == PBC_HDR_LAST) begin
                            next_cur.fsm   = PBC_TA;
                            next_cur.bcnt  = 4'h0;
                            next_cur.regad = hdr[4:0];
                            next_cur.rd    = (hdr[11:10] == PBC_OP_READ) && addr_hit;
                            next_cur.wr    = (hdr[11:10] == PBC_OP_WRITE) && addr_hit;
                        end
                    end
                    PBC_TA: begin
                        next_cur.bcnt = 4'h1;
                        if (cur.bcnt == 4'h0) begin
                            // Drive the second turnaround bit low on a read.
                            next_cur.mdio_oe  = cur.rd;
                            next_cur.mdio_out = 1'b0;
                        end else begin
                            next_cur.fsm      = PBC_DATA;
                            next_cur.bcnt     = 4'h0;
                            next_cur.sr       = rdata;
                            next_cur.mdio_out = rdata[15];
                        end
                    end
                    PBC_DATA: begin
                        next_cur.sr       = shifted;
                        next_cur.mdio_out = shifted[15];
                        next_cur.bcnt     = cur.bcnt + 4'h1;
                        if (cur.bcnt == PBC_DATA_LAST) begin
                            next_cur.fsm     = PBC_IDLE;
                            next_cur.mdio_oe = 1'b0;
                            next_cur.rd      = 1'b0;
                            next_cur.wr      = 1'b0;
                            if (cur.wr && (cur.regad == PBC_ADDR_PAGE)) begin
                                next_cur.page = shifted;
                            end else if (ctrl_write) begin
                                if (shifted[PBC_CTRL_SRESET]) begin
                                    // Every register returns to default; the bit is never stored.
                                    next_cur.ctrl     = CTRL_DEF;
                                    next_cur.page     = PBC_PAGE_RST;
                                    next_cur.far_lat  = 1'b0;
                                    next_cur.link_lat = 1'b0;
                                    next_cur.jab_lat  = 1'b0;
                                    next_cur.sreset   = 1'b1;
                                end else begin
                                    // Fields land together; the restart strobe is a pulse only.
                                    next_cur.ctrl       = ctrl_wr;
                                    next_cur.an_restart = shifted[PBC_CTRL_AN_RST];
                                end
                            end
                        end
                    end
                    // An illegal state code drops back to waiting for a frame start.
                    default: begin
                        next_cur.fsm = PBC_IDLE;
                    end
                endcase
            end
            // A status read rearms the latches to the live condition.
            if (stat_clr) begin
                next_cur.far_lat  = 1'b0;
                next_cur.jab_lat  = 1'b0;
                next_cur.link_lat = 1'b1;
            end
            // Events are applied last so that a set in the clearing cycle wins.
            next_cur.far_lat  = next_cur.far_lat | media_i.far_fault;
            next_cur.jab_lat  = next_cur.jab_lat | media_i.jabber;
            next_cur.link_lat = next_cur.link_lat & media_i.link_up;
        end
    end

    // ==========================================================================
    // State register
    // ==========================================================================
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur          <= '0;
            cur.fsm      <= PBC_IDLE;
            cur.page     <= PBC_PAGE_RST;
            cur.ctrl     <= CTRL_DEF;
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================================
    // Outputs
    // ==========================================================================
    // Loopback uses the same speed and duplex fields as normal operation.
    assign ctrl_o       = cur.ctrl;
    assign an_restart_o = cur.an_restart;
    assign soft_reset_o = cur.sreset;
    assign mdio_o       = cur.mdio_out;
    assign mdio_oe_o    = cur.mdio_oe;

    // ==========================================================================
    // Checks
    // ==========================================================================
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    chk_sreset_default: assert property (
        soft_reset_o |-> (ctrl_word == PBC_CTRL_RST) && (cur.page == PBC_PAGE_RST) && !an_restart_o)
        else $error("soft reset did not restore control defaults");

    chk_sreset_selfclr: assert property (
        soft_reset_o |=> !soft_reset_o && !ctrl_word[PBC_CTRL_SRESET])
        else $error("soft reset bit did not clear itself");

    chk_speed_field: assert property (
        ctrl_o.speed == pbc_speed_t'({ctrl_word[PBC_CTRL_SPD_MSB], ctrl_word[PBC_CTRL_SPD_LSB]}))
        else $error("speed output does not match control bits 6 and 13");

    chk_restart_pulse: assert property (
        an_restart_o |-> !ctrl_word[PBC_CTRL_AN_RST] ##1 (!an_restart_o || !ce_i))
        else $error("restart pulse longer than one cycle");

    chk_ctrl_frozen: assert property (
        (!main_page && $stable(cur.page)) |=> $stable(ctrl_word) || !ce_i || !$stable(cur.page))
        else $error("control changed while another page was selected");

    chk_fault_latch: assert property (
        (ce_i && media_i.far_fault) |=> stat_word[PBC_STAT_FAULT])
        else $error("far-end fault not latched");

    chk_jabber_latch: assert property (
        (ce_i && media_i.jabber) |=> cur.jab_lat [*1] ##0 stat_word[PBC_STAT_JABBER])
        else $error("jabber not latched");

    chk_link_latch: assert property (
        (ce_i && !media_i.link_up) |=> !stat_word[PBC_STAT_LINK])
        else $error("link loss not latched low");

    chk_status_rearm: assert property (
        (stat_clr && media_i.link_up && !media_i.jabber && !media_i.far_fault)
        |=> cur.link_lat && !cur.jab_lat && !cur.far_lat)
        else $error("status latches not returned to live value");

    chk_fixed_caps: assert property (
        (stat_word[15:6] == PBC_STAT_FIXED[15:6]) && stat_word[3] && stat_word[0])
        else $error("fixed capability bits wrong");

    chk_ta_low: assert property (
        $rose(mdio_oe_o) |-> !mdio_o ##1 (mdio_oe_o [*3]))
        else $error("turnaround bit not driven low");

    chk_page_gate: assert property (
        (ce_i && mdc_rise && (cur.fsm == PBC_TA) && (cur.bcnt == 4'h1) && !main_page
         && (cur.regad != PBC_ADDR_PAGE)) |=> (cur.sr == 16'h0000))
        else $error("main-page word readable while another page is selected");

    chk_ctrl_hold: assert property (
        (cur.fsm != PBC_DATA) |=> $stable(ctrl_o))
        else $error("port control changed outside a register write");

endmodule

`default_nettype wire

// ---- hw/pbc_sync.sv ----
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none

module pbc_sync
    import pbc_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    // Clock, reset and enable
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    input  wire logic ce_i,
    // Asynchronous input and filtered level
    input  wire logic din_i,
    output logic      q_o
);

    pbc_sync_state_t cur;
    pbc_sync_state_t next_cur;

    // ==========================================================================
    // Stage shifting and agreement filter
    // ==========================================================================
    // The first stage feeds only the second, so a metastable value never reaches logic.
    always_comb begin
        next_cur = cur;
        if (ce_i) begin
            next_cur.stage = {cur.stage[PBC_SYNC_STAGES-2:0], din_i};
            if (cur.stage[1] == cur.stage[2]) begin
                next_cur.q = cur.stage[2];
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur <= '{stage: {PBC_SYNC_STAGES{RST_VAL}}, q: RST_VAL};
        end else begin
            cur <= next_cur;
        end
    end

    assign q_o = cur.q;

endmodule

`default_nettype wire

// ---- sim/pbc_smi_station.sv ----
// Behavioural station management controller that sends frames on the management pins.
`timescale 1ns/1ns
`default_nettype none

module pbc_smi_station
    import pbc_pkg::*;
(
    // Core clock paces the management clock
    input  wire logic clk_i,
    // Resolved management wire and our drive
    input  wire logic mdio_i,
    output logic      mdc_o,
    output logic      mdio_o,
    output logic      mdio_oe_o
);
    // ==========================================================================
    // Frame driver
    // ==========================================================================
    // The management clock stands low outside frames.
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b0;
        mdio_oe_o = 1'b0;
    end

    // Half of a 400 ns management clock period.
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask

    // Drives one bit and samples the wire just before the rising edge.
    task automatic bit_io(input logic b, input logic oe, output logic s);
        mdio_oe_o = oe;
        mdio_o = b;
        half();
        s = mdio_i;
        mdc_o = 1'b1;
        half();
        mdc_o = 1'b0;
    endtask

    // Sends one frame; a read returns its data in d.
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input int pre, inout logic [15:0] d);
        logic [13:0] hdr;
        logic        s;
        logic        wr;
        hdr = {2'b01, op, pa, ra};
        wr = (op == PBC_OP_WRITE);
        repeat (pre) bit_io(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
        bit_io(1'b1, wr, s);
        bit_io(1'b0, wr, s);
        for (int i = 15; i >= 0; i--) begin
            bit_io(d[i], wr, s);
            if (!wr) d[i] = s;
        end
        mdio_oe_o = 1'b0;
        // A quiet gap follows every frame, so a soft reset settles first.
        repeat (8) half();
    endtask
endmodule
`default_nettype wire

// ---- sim/test_pbc_regs.sv ----
// Self-checking bench of the basic control and status registers.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end

module test_pbc_regs;
    import pbc_pkg::*;
    localparam logic [21:0] MC = 22'h2b61d4;  // Arbitrary value.
    localparam logic [5:0]  MN = 6'h1a;       // Arbitrary value.
    localparam logic [3:0]  RV = 4'h5;        // Arbitrary value.
    logic        core_clk_i, resetn_i, mdc, st_o, st_oe, dut_o, dut_oe, mdio_w, an_rst, sreset, an;
    logic [4:0]  paddr;
    logic [15:0] d, v;
    pbc_media_t  media;
    pbc_ctrl_t   ctrl;
    int          err_count, n_compared, n_an, n_sr, seed, k;

    // The management line has a pull-up when nobody drives it.
    assign mdio_w = dut_oe ? dut_o : (st_oe ? st_o : 1'b1);

    pbc_regs #(.MAKER_CODE(MC), .MODEL_NUM(MN), .REV_NUM(RV)) pbc_regs_inst (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .mdc_i(mdc),
        .mdio_i(mdio_w), .mdio_o(dut_o), .mdio_oe_o(dut_oe), .phy_addr_i(paddr),
        .media_i(media), .ctrl_o(ctrl), .an_restart_o(an_rst), .soft_reset_o(sreset));
    pbc_smi_station pbc_smi_station_inst (.clk_i(core_clk_i), .mdio_i(mdio_w), .mdc_o(mdc),
        .mdio_o(st_o), .mdio_oe_o(st_oe));

    // 20 MHz core clock.
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    // Counts the one-cycle pulses so none is missed between frames.
    always @(posedge core_clk_i) begin
        if (an_rst === 1'b1) n_an++;
        if (sreset === 1'b1) n_sr++;
    end

    // ==========================================================================
    // Helpers
    // ==========================================================================
    task automatic print_verdict();
        $display("compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // A random choice of long preamble or none at all.
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        inout logic [15:0] x);
        pbc_smi_station_inst.frame(op, pa, ra, ($random(seed) & 1) ? 32 : 0, x);
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] x);
        xfer(PBC_OP_WRITE, paddr, ra, x);
    endtask

    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
        d = 16'h0000;
        xfer(PBC_OP_READ, pa, ra, d);
        `CHK(d, e)
    endtask

    function automatic logic [15:0] st_exp(logic far, logic lnk, logic jab);
        return 16'h79c9 | {10'h000, an, far, 1'b0, lnk, jab, 1'b0};
    endfunction

    function automatic pbc_ctrl_t ctrl_exp(logic [15:0] w);
        return pbc_ctrl_t'({w[14], w[6], w[13], w[12], w[11], w[10], w[8], w[7]});
    endfunction

    // Stops a hung run.
    initial begin
        #4000000;
        err_count++;
        print_verdict();
    end

    // ==========================================================================
    // Main sequence
    // ==========================================================================
    initial begin
        seed = 32'heb04;
        {err_count, n_compared, n_an, n_sr} = '0;
        resetn_i = 1'b0;
        paddr = 5'h0b;
        an = 1'b1;
        media = '{link_up: 1'b1, jabber: 1'b0, far_fault: 1'b0, an_done: 1'b1};
        repeat (2) @(negedge core_clk_i);
        resetn_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        `CHK(ctrl, pbc_ctrl_t'(8'h50))
        rd(paddr, PBC_ADDR_CTRL, 16'h1040);
        rd(paddr, PBC_ADDR_STATUS, st_exp(0, 0, 0));
        rd(paddr, PBC_ADDR_STATUS, st_exp(0, 1, 0));
        rd(paddr, PBC_ADDR_ID_HI, MC[21:6]);
        rd(paddr, PBC_ADDR_ID_LO, {MC[5:0], MN, RV});
        // Short fault, jabber and link loss pulses must be held until read.
        an = $random(seed);
        media = '{link_up: 1'b0, jabber: 1'b1, far_fault: 1'b1, an_done: an};
        repeat (2) @(negedge core_clk_i);
        media = '{link_up: 1'b1, jabber: 1'b0, far_fault: 1'b0, an_done: an};
        rd(paddr, PBC_ADDR_STATUS, st_exp(1, 0, 1));
        rd(paddr, PBC_ADDR_STATUS, st_exp(0, 1, 0));
        // Every speed code with random other control bits.
        for (int s = 0; s < 4; s++) begin
            v = 16'($random(seed)) & 16'h5f80;
            v[13] = s[0];
            v[6] = s[1];
            k = n_an;
            wr(PBC_ADDR_CTRL, v);
            `CHK(ctrl, ctrl_exp(v))
            `CHK(n_an, k + int'(v[9]))
            rd(paddr, PBC_ADDR_CTRL, v & 16'h7dc0);
        end
        // Main page is closed while the page register is nonzero.
        wr(PBC_ADDR_PAGE, 16'h0001 | 16'($random(seed)));
        rd(paddr, PBC_ADDR_CTRL, 16'h0000);
        wr(PBC_ADDR_CTRL, 16'h4900);
        wr(PBC_ADDR_PAGE, 16'h0000);
        rd(paddr, PBC_ADDR_CTRL, v & 16'h7dc0);
        rd(paddr ^ 5'h01, PBC_ADDR_CTRL, 16'hffff);
        rd(paddr, 5'h05, 16'h0000);
        // Soft reset with loopback requested in the same word.
        k = n_sr;
        wr(PBC_ADDR_PAGE, 16'h0003);
        wr(PBC_ADDR_CTRL, 16'hc000);
        `CHK(n_sr, k)
        wr(PBC_ADDR_PAGE, 16'h0000);
        wr(PBC_ADDR_CTRL, 16'hc000);
        `CHK(n_sr, k + 1)
        `CHK(ctrl, pbc_ctrl_t'(8'h50))
        rd(paddr, PBC_ADDR_CTRL, 16'h1040);
        // Forced gigabit: role chosen first, power-down cycled after a link loss.
        wr(5'h09, 16'h0800);
        wr(PBC_ADDR_CTRL, 16'h0140);
        `CHK(ctrl, ctrl_exp(16'h0140))
        media = '{link_up: 1'b0, jabber: 1'b0, far_fault: 1'b0, an_done: an};
        repeat (2) @(negedge core_clk_i);
        media = '{link_up: 1'b1, jabber: 1'b0, far_fault: 1'b0, an_done: an};
        rd(paddr, PBC_ADDR_STATUS, st_exp(0, 0, 0));
        wr(PBC_ADDR_CTRL, 16'h0940);
        `CHK(ctrl, ctrl_exp(16'h0940))
        wr(PBC_ADDR_CTRL, 16'h0140);
        `CHK(ctrl, ctrl_exp(16'h0140))
        rd(paddr, PBC_ADDR_STATUS, st_exp(0, 1, 0));
        print_verdict();
    end
endmodule
`default_nettype wire
